// File: hdl/ddc_pkg.sv
/*
 * shared constants for the dual-address dma channel: register map,
 * field positions, step modes and trigger code.
 * assumes a 32-bit ahb-lite register bus and 16-bit memory data paths.
 */
package ddc_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [19:0] IDX_TRIG_SEL = 20'h40299;
    localparam logic [19:0] IDX_CNT_LO = 20'h48250;
    localparam logic [19:0] IDX_CTRL = 20'h48252;
    localparam logic [19:0] IDX_SRC_LO = 20'h48254;
    localparam logic [19:0] IDX_SRC_HI = 20'h48256;
    localparam logic [19:0] IDX_DST_LO = 20'h48258;
    localparam logic [19:0] IDX_DST_HI = 20'h4825A;
    localparam logic [19:0] IDX_ENABLE = 20'h4825C;
    localparam logic [19:0] IDX_PEND = 20'h4825E;
    localparam logic [19:0] IDX_IRQ_STAT = 20'h48260;
    localparam logic [19:0] IDX_IRQ_MASK = 20'h48262;
    localparam int IDX_W = 20;
    localparam int AW = 28;
    localparam int CW = 24;
    // field positions
    localparam int F_TRIG_LSB = 4;
    localparam int F_STEP_LSB = 12;
    localparam int F_SIZE_BIT = 14;
    localparam int F_MODE_LSB = 14;
    localparam int F_DUAL_BIT = 15;
    localparam logic [3:0] TRIG_USB_REQ = 4'h1;
    localparam logic [1:0] STEP_FIXED = 2'h0;
    localparam logic [1:0] STEP_DEC = 2'h1;
    localparam logic [27:0] UNIT_BYTE = 28'h0000001;
    localparam logic [27:0] UNIT_HALF = 28'h0000002;
    localparam logic [23:0] CNT_ONE = 24'h000001;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    // status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TRIG = 1;
    localparam int IRQ_N = 2;
endpackage

// File: hdl/ddc_tmp_reg.sv
/*
 * temporary data register between the read and write phases.
 * assumes load is a one-cycle strobe from the channel sequencer.
 */
`timescale 1ns/10ps
`default_nettype none
module ddc_tmp_reg (
    // clock and control
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // data
    input wire logic i_load,
    input wire logic [15:0] i_data,
    output logic [15:0] o_data
);
    logic [15:0] data_r;
    logic [15:0] data_nxt;
    always_comb begin
        data_nxt = data_r;
        if (i_load) begin
            data_nxt = i_data;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            data_r <= 16'h0000;
        end else if (i_ce) begin
            data_r <= data_nxt;
        end
    end
    assign o_data = data_r;
endmodule
`default_nettype wire

// File: hdl/ddc_channel.sv
/*
 * one dual-address single-transfer dma channel with ahb-lite registers
 * and a simple memory master port (read phase, then write phase).
 * assumes memory answers with a one-cycle o_mem_req / i_mem_ack pair and
 * that the usb request line is asynchronous to I_CLK.
 */
// Operation
// [R1] unit size bit zero selects byte transfers
// [R2] 24-bit count split over counter low and control byte fields
// [R3] count decrements per transfer; zero wraps to all ones
// [R4] 28-bit source and destination addresses, 16 low and 12 high bits
// [R5] step 00 keeps the address fixed
// [R6] step 01 subtracts the unit size after each transfer
// [R7] step 10 or 11 adds the unit size after each transfer
// [R8] trigger select 0001 picks the usb request falling edge
// [R9] trigger ignores interrupt controller flags; factor flag not cleared
// [R10] triggers set a pending flag, cleared when a transfer starts
// [R11] pending flag reads 1 when set; writing 1 cancels it
// [R12] enable bit starts the channel; cleared enable blocks requests
// [R13] control writes blocked while enable is set
// [R14] enable clears when the count reaches zero
// [R15] completion interrupt only when the count reaches zero
// [R16] software keeps usb transfer addresses in 0x100000..0x1FFFFF
// [R17] each transfer reads source into temp then writes destination
// [R18] each trigger moves exactly one unit
`timescale 1ns/10ps
`default_nettype none
module ddc_channel (
    // clock, reset, enable
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic [1:0] O_HRESP,
    // usb request pin, active low
    input wire logic I_USB_REQ_N,
    // memory master
    output logic O_MEM_REQ,
    output logic O_MEM_WRITE,
    output logic [27:0] O_MEM_ADDR,
    output logic [2:0] O_MEM_SIZE,
    output logic [15:0] O_MEM_WDATA,
    input wire logic [15:0] I_MEM_RDATA,
    input wire logic I_MEM_ACK,
    // interrupt and trigger factor
    output logic O_IRQ,
    output logic O_TRIG_FACTOR
);
    // ****************************************************************
    // register state
    // ****************************************************************
    typedef enum {ST_IDLE, ST_RD, ST_WR} ddc_state_t;
    ddc_state_t st_r, st_nxt;
    logic [7:0] trig_sel_r, trig_sel_nxt;
    logic [15:0] cnt_lo_r, cnt_lo_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] src_hi_r, src_hi_nxt;
    logic [15:0] dst_hi_r, dst_hi_nxt;
    logic [27:0] src_r, src_nxt;
    logic [27:0] dst_r, dst_nxt;
    logic en_r, en_nxt;
    logic pend_r, pend_nxt;
    logic [1:0] irq_st_r, irq_st_nxt;
    logic [1:0] irq_mk_r, irq_mk_nxt;
    logic wr_ph_r, wr_ph_nxt;
    logic [ddc_pkg::IDX_W-1:0] wr_idx_r, wr_idx_nxt;
    logic [2:0] req_sync_r;
    logic [23:0] cnt;
    logic [27:0] unit;
    logic trig_edge, start, done_xfer, tmp_load;
    logic [15:0] tmp_q;
    logic [31:0] rdata_r, rdata_nxt;
    logic [ddc_pkg::IDX_W-1:0] a_idx;
    logic a_go, prot;

    assign cnt = {ctrl_r[7:0], cnt_lo_r}; // [R2]
    // size bit zero means a byte unit
    assign unit = src_hi_r[ddc_pkg::F_SIZE_BIT] ? ddc_pkg::UNIT_HALF
                                                : ddc_pkg::UNIT_BYTE; // [R1]

    // ****************************************************************
    // trigger detection
    // ****************************************************************
    // bit 0 is only the first synchroniser stage
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            req_sync_r <= 3'h7;
        end else if (I_CE) begin
            req_sync_r <= {req_sync_r[1:0], I_USB_REQ_N};
        end
    end
    // falling edge, selected only by code 0001; interrupt controller
    // state plays no part and the factor pulse is left for it
    assign trig_edge = req_sync_r[2] & ~req_sync_r[1] &
        (trig_sel_r[ddc_pkg::F_TRIG_LSB +: 4] == ddc_pkg::TRIG_USB_REQ);
    // [R8] [R9]
    assign O_TRIG_FACTOR = req_sync_r[2] & ~req_sync_r[1];

    // a queued trigger starts only an enabled idle channel
    assign start = pend_r & en_r & (st_r == ST_IDLE); // [R10] [R12]
    assign done_xfer = (st_r == ST_WR) & I_MEM_ACK;
    assign tmp_load = (st_r == ST_RD) & I_MEM_ACK;

    ddc_tmp_reg u_tmp (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_ce(I_CE),
        .i_load(tmp_load),
        .i_data(I_MEM_RDATA),
        .o_data(tmp_q)
    );

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign a_go = I_HSEL & I_HREADY & (I_HTRANS == ddc_pkg::HTRANS_NONSEQ);
    assign a_idx = I_HADDR[ddc_pkg::IDX_W+1:2];
    // control information locked while the channel is enabled
    assign prot = en_r; // [R13]

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        trig_sel_nxt = trig_sel_r;
        cnt_lo_nxt = cnt_lo_r;
        ctrl_nxt = ctrl_r;
        src_hi_nxt = src_hi_r;
        dst_hi_nxt = dst_hi_r;
        src_nxt = src_r;
        dst_nxt = dst_r;
        en_nxt = en_r;
        pend_nxt = pend_r;
        irq_st_nxt = irq_st_r;
        irq_mk_nxt = irq_mk_r;
        wr_ph_nxt = a_go & I_HWRITE;
        wr_idx_nxt = a_idx;
        rdata_nxt = rdata_r;
        // register writes in the data phase
        if (wr_ph_r) begin
            case (wr_idx_r)
                ddc_pkg::IDX_TRIG_SEL: trig_sel_nxt = I_HWDATA[7:0];
                ddc_pkg::IDX_CNT_LO: if (!prot) cnt_lo_nxt = I_HWDATA[15:0];
                ddc_pkg::IDX_CTRL: if (!prot) ctrl_nxt = I_HWDATA[15:0];
                ddc_pkg::IDX_SRC_LO: if (!prot) begin
                    src_nxt[15:0] = I_HWDATA[15:0]; // [R4]
                end
                ddc_pkg::IDX_SRC_HI: if (!prot) begin
                    src_hi_nxt = I_HWDATA[15:0];
                    src_nxt[27:16] = I_HWDATA[11:0]; // [R4]
                end
                ddc_pkg::IDX_DST_LO: if (!prot) begin
                    dst_nxt[15:0] = I_HWDATA[15:0];
                end
                ddc_pkg::IDX_DST_HI: if (!prot) begin
                    dst_hi_nxt = I_HWDATA[15:0];
                    dst_nxt[27:16] = I_HWDATA[11:0];
                end
                ddc_pkg::IDX_ENABLE: en_nxt = I_HWDATA[0]; // [R12]
                ddc_pkg::IDX_PEND: if (I_HWDATA[0]) begin
                    pend_nxt = 1'b0; // [R11]
                end
                ddc_pkg::IDX_IRQ_STAT:
                    irq_st_nxt = irq_st_r & ~I_HWDATA[1:0];
                ddc_pkg::IDX_IRQ_MASK: irq_mk_nxt = I_HWDATA[1:0];
                default: ;
            endcase
        end
        // hardware events after software so a set wins over a clear
        if (trig_edge) begin
            pend_nxt = 1'b1; // [R10]
            irq_st_nxt[ddc_pkg::IRQ_TRIG] = 1'b1;
        end
        case (st_r)
            ST_IDLE: if (start) begin
                if (!trig_edge) pend_nxt = 1'b0; // [R10]
                st_nxt = ST_RD; // [R17]
            end
            ST_RD: if (I_MEM_ACK) st_nxt = ST_WR; // [R17]
            ST_WR: if (I_MEM_ACK) begin
                // one unit per trigger, then back to idle
                st_nxt = ST_IDLE; // [R18]
                {ctrl_nxt[7:0], cnt_lo_nxt} = cnt - ddc_pkg::CNT_ONE; // [R3]
                case (src_hi_r[ddc_pkg::F_STEP_LSB +: 2])
                    ddc_pkg::STEP_FIXED: ; // [R5]
                    ddc_pkg::STEP_DEC: src_nxt = src_r - unit; // [R6]
                    default: src_nxt = src_r + unit; // [R7]
                endcase
                case (dst_hi_r[ddc_pkg::F_STEP_LSB +: 2])
                    ddc_pkg::STEP_FIXED: ; // [R5]
                    ddc_pkg::STEP_DEC: dst_nxt = dst_r - unit; // [R6]
                    default: dst_nxt = dst_r + unit; // [R7]
                endcase
                if (cnt == ddc_pkg::CNT_ONE) begin
                    en_nxt = 1'b0; // [R14]
                    irq_st_nxt[ddc_pkg::IRQ_DONE] = 1'b1; // [R15]
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // read data latched in the address phase
        if (a_go && !I_HWRITE) begin
            case (a_idx)
                ddc_pkg::IDX_TRIG_SEL: rdata_nxt = {24'h000000, trig_sel_r};
                ddc_pkg::IDX_CNT_LO: rdata_nxt = {16'h0000, cnt_lo_r};
                ddc_pkg::IDX_CTRL: rdata_nxt = {16'h0000, ctrl_r};
                ddc_pkg::IDX_SRC_LO: rdata_nxt = {16'h0000, src_r[15:0]};
                ddc_pkg::IDX_SRC_HI:
                    rdata_nxt = {16'h0000, src_hi_r[15:12], src_r[27:16]};
                ddc_pkg::IDX_DST_LO: rdata_nxt = {16'h0000, dst_r[15:0]};
                ddc_pkg::IDX_DST_HI:
                    rdata_nxt = {16'h0000, dst_hi_r[15:12], dst_r[27:16]};
                ddc_pkg::IDX_ENABLE: rdata_nxt = {31'h00000000, en_r};
                ddc_pkg::IDX_PEND: rdata_nxt = {31'h00000000, pend_r}; // [R11]
                ddc_pkg::IDX_IRQ_STAT: rdata_nxt = {30'h00000000, irq_st_r};
                ddc_pkg::IDX_IRQ_MASK: rdata_nxt = {30'h00000000, irq_mk_r};
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st_r <= ST_IDLE;
            trig_sel_r <= 8'h00;
            cnt_lo_r <= 16'h0000;
            ctrl_r <= 16'h0000;
            src_hi_r <= 16'h0000;
            dst_hi_r <= 16'h0000;
            src_r <= 28'h0000000;
            dst_r <= 28'h0000000;
            en_r <= 1'b0;
            pend_r <= 1'b0;
            irq_st_r <= 2'h0;
            irq_mk_r <= 2'h0;
            wr_ph_r <= 1'b0;
            wr_idx_r <= 20'h00000;
            rdata_r <= 32'h00000000;
        end else if (I_CE) begin
            st_r <= st_nxt;
            trig_sel_r <= trig_sel_nxt;
            cnt_lo_r <= cnt_lo_nxt;
            ctrl_r <= ctrl_nxt;
            src_hi_r <= src_hi_nxt;
            dst_hi_r <= dst_hi_nxt;
            src_r <= src_nxt;
            dst_r <= dst_nxt;
            en_r <= en_nxt;
            pend_r <= pend_nxt;
            irq_st_r <= irq_st_nxt;
            irq_mk_r <= irq_mk_nxt;
            wr_ph_r <= wr_ph_nxt;
            wr_idx_r <= wr_idx_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign O_HRDATA = rdata_r;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = ddc_pkg::HRESP_OKAY;
    assign O_IRQ = |(irq_st_r & irq_mk_r);
    assign O_MEM_REQ = (st_r == ST_RD) | (st_r == ST_WR);
    assign O_MEM_WRITE = (st_r == ST_WR);
    assign O_MEM_ADDR = (st_r == ST_WR) ? dst_r : src_r;
    assign O_MEM_SIZE = src_hi_r[ddc_pkg::F_SIZE_BIT] ? ddc_pkg::HSIZE_HALF
                                                      : ddc_pkg::HSIZE_BYTE;
    assign O_MEM_WDATA = tmp_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_done_clears_en;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && done_xfer && cnt == ddc_pkg::CNT_ONE) |=> !en_r;
    endproperty
    a_done_clears_en: assert property (p_done_clears_en) // [R14]
        else $error("enable not cleared at count end");
    property p_done_irq;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && done_xfer && cnt == ddc_pkg::CNT_ONE) |=> irq_st_r[0];
    endproperty
    a_done_irq: assert property (p_done_irq) // [R15]
        else $error("completion status not set");
    property p_irq_only_end;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && done_xfer && cnt != ddc_pkg::CNT_ONE && !irq_st_r[0])
        |=> !irq_st_r[0];
    endproperty
    a_irq_only_end: assert property (p_irq_only_end) // [R15]
        else $error("completion status set early");
    property p_cnt_dec;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && done_xfer) |=> cnt == $past(cnt) - ddc_pkg::CNT_ONE;
    endproperty
    a_cnt_dec: assert property (p_cnt_dec) // [R3]
        else $error("count not decremented");
    property p_trig_pend;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && trig_edge) |=> pend_r;
    endproperty
    a_trig_pend: assert property (p_trig_pend) // [R10]
        else $error("trigger not queued");
    property p_start_clears;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && start && !trig_edge) |=> !pend_r && st_r == ST_RD;
    endproperty
    a_start_clears: assert property (p_start_clears) // [R10]
        else $error("start did not take pending trigger");
    property p_no_start_disabled;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && st_r == ST_IDLE && !en_r) |=> st_r == ST_IDLE;
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled) // [R12]
        else $error("disabled channel started");
    property p_lock;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && en_r && st_r == ST_IDLE && !start) |=> $stable(src_r);
    endproperty
    a_lock: assert property (p_lock) // [R13]
        else $error("source changed while enabled");
    property p_rd_then_wr;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && tmp_load)
        |=> O_MEM_WRITE && O_MEM_WDATA == $past(I_MEM_RDATA);
    endproperty
    a_rd_then_wr: assert property (p_rd_then_wr) // [R17]
        else $error("write phase lost read data");
    property p_fixed;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CE && done_xfer &&
         src_hi_r[ddc_pkg::F_STEP_LSB +: 2] == ddc_pkg::STEP_FIXED)
        |=> $stable(src_r);
    endproperty
    a_fixed: assert property (p_fixed) // [R5]
        else $error("fixed address moved");
    c_xfer: cover property (@(posedge I_CLK) done_xfer);
    c_end: cover property (@(posedge I_CLK)
        done_xfer && cnt == ddc_pkg::CNT_ONE);
    c_queue: cover property (@(posedge I_CLK) trig_edge && st_r != ST_IDLE);
endmodule
`default_nettype wire

// File: verification/ddc_mem_model.sv
/*
 * partner model: memory answering the channel's read and write phases
 * after 0..2 wait cycles, plus the usb controller's request pin.
 * assumes one clock and a one-cycle i_fire strobe from the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module ddc_mem_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // usb request side
    input wire logic i_fire,
    output logic o_usb_req_n,
    // memory side
    input wire logic i_req,
    input wire logic i_write,
    input wire logic [27:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0] o_rdata,
    output logic o_ack,
    // record of traffic
    output logic [15:0] o_n_rd,
    output logic [15:0] o_n_wr,
    output logic [27:0] o_rd_addr,
    output logic [27:0] o_wr_addr,
    output logic [15:0] o_wr_data
);
    logic [1:0] wait_r;
    logic [2:0] low_r;
    logic hit;
    // ************
    // behaviour
    // ************
    // each strobe gives one low pulse; its falling edge triggers
    always_ff @(posedge i_clk) begin
        if (i_rst) low_r <= 3'h0;
        else if (i_fire) low_r <= 3'h4;
        else if (low_r != 3'h0) low_r <= low_r - 3'h1;
    end
    assign o_usb_req_n = (low_r == 3'h0);
    assign hit = !i_rst && i_req && !o_ack && wait_r == 2'h0;
    // data lines toggle outside an answer so stale data never passes
    always_ff @(posedge i_clk) begin
        o_ack <= hit;
        if (i_rst || !i_req || o_ack) wait_r <= 2'($urandom_range(2));
        else if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
        if (i_rst) o_rdata <= 16'h5A5A;
        else if (hit && !i_write) o_rdata <= {8'h00, i_addr[7:0] ^ 8'hA5};
        else o_rdata <= ~o_rdata;
        if (i_rst) begin
            o_n_rd <= 16'h0;
            o_n_wr <= 16'h0;
        end else if (o_ack && i_req && i_write) begin
            o_n_wr <= o_n_wr + 16'h1;
            o_wr_addr <= i_addr;
            o_wr_data <= i_wdata;
        end else if (o_ack && i_req) begin
            o_n_rd <= o_n_rd + 16'h1;
            o_rd_addr <= i_addr;
        end
    end
endmodule
`default_nettype wire

// File: verification/test_dual_address_dma_channel.sv
/*
 * self-checking bench for the dma channel: ahb-lite master tasks,
 * queued triggers, step modes, count wrap and interrupts.
 * assumes the memory/usb partner model and a zero-wait slave.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, g); n_fail++; end end
module test_dual_address_dma_channel;
    logic clk, rst, fire, hwrite, usb_n, mreq, mwr, mack, irq, tfac, hready;
    logic [1:0] htrans, hresp;
    logic [2:0] hsize, msize;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [27:0] maddr, rd_a, wr_a, s, d, a;
    logic [15:0] mwd, mrd, n_rd, n_wr, wr_d, n0;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_tf = 0;
    ddc_channel dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_HSEL(1'b1),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_USB_REQ_N(usb_n), .O_MEM_REQ(mreq), .O_MEM_WRITE(mwr),
        .O_MEM_ADDR(maddr), .O_MEM_SIZE(msize), .O_MEM_WDATA(mwd),
        .I_MEM_RDATA(mrd), .I_MEM_ACK(mack), .O_IRQ(irq),
        .O_TRIG_FACTOR(tfac));
    ddc_mem_model mem (.i_clk(clk), .i_rst(rst), .i_fire(fire),
        .o_usb_req_n(usb_n), .i_req(mreq), .i_write(mwr), .i_addr(maddr),
        .i_wdata(mwd), .o_rdata(mrd), .o_ack(mack), .o_n_rd(n_rd),
        .o_n_wr(n_wr), .o_rd_addr(rd_a), .o_wr_addr(wr_a), .o_wr_data(wr_d));
    // ************
    // tasks
    // ************
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [19:0] i,
                       input logic [15:0] v);
        @(posedge clk);
        haddr <= {10'h000, i, 2'b00};
        htrans <= ddc_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {16'h0000, v};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rv = hrdata;
        `CHK("response", ddc_pkg::HRESP_OKAY, hresp);
    endtask
    task automatic wr(input logic [19:0] i, input logic [15:0] v);
        bus(1'b1, i, v);
    endtask
    task automatic rd(input logic [19:0] i);
        bus(1'b0, i, 16'h0000);
    endtask
    task automatic rd_a28(input logic [19:0] lo);
        rd(lo);
        a[15:0] = rv[15:0];
        rd(lo + 20'h2);
        a[27:16] = rv[11:0];
    endtask
    task automatic wait_wr(input logic [15:0] n);
        for (int i = 0; i < 60 && n_wr !== n; i++) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic trig(input logic x);
        int t0;
        n0 = n_wr;
        t0 = n_tf;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        wait_wr(n0 + {15'h0, x});
        if (!x) repeat (20) @(posedge clk);
        `CHK("transfers", n0 + {15'h0, x}, n_wr);
        `CHK("factor pulse", t0 + 1, n_tf);
    endtask
    task automatic setup(input logic [1:0] sm, input logic [1:0] dm,
                         input logic [23:0] n);
        wr(ddc_pkg::IDX_CNT_LO, n[15:0]);
        wr(ddc_pkg::IDX_CTRL, {8'h80, n[23:16]});
        wr(ddc_pkg::IDX_SRC_LO, s[15:0]);
        wr(ddc_pkg::IDX_SRC_HI, {2'b00, sm, s[27:16]});
        wr(ddc_pkg::IDX_DST_LO, d[15:0]);
        wr(ddc_pkg::IDX_DST_HI, {2'b00, dm, d[27:16]});
        wr(ddc_pkg::IDX_ENABLE, 16'h0001);
    endtask
    task automatic chk_xfer();
        `CHK("read addr", s, rd_a);
        `CHK("write addr", d, wr_a);
        `CHK("write data", s[7:0] ^ 8'hA5, wr_d[7:0]);
        `CHK("phases", n_rd, n_wr);
    endtask
    function automatic logic [27:0] stp(logic [27:0] x, logic [1:0] m);
        return m == 2'h0 ? x : m == 2'h1 ? x - 28'h1 : x + 28'h1;
    endfunction
    // ************
    // stimulus
    // ************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end
    always @(posedge clk) begin
        if (mreq === 1'b1)
            `CHK("unit size", ddc_pkg::HSIZE_BYTE, msize);
        if (tfac === 1'b1)
            n_tf++;
    end
    initial begin
        rst = 1'b1;
        fire = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        void'($urandom(32'h2D97));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(ddc_pkg::IDX_ENABLE);
        `CHK("enable", 16'h0, rv[15:0]);
        rd(20'h48300);
        `CHK("unmapped", 16'h0, rv[15:0]);
        // select still 0000 after reset: the edge must not queue
        trig(1'b0);
        rd(ddc_pkg::IDX_PEND);
        `CHK("other select", 16'h0, rv[15:0]);
        wr(ddc_pkg::IDX_TRIG_SEL, 16'h0010);
        trig(1'b0);
        rd(ddc_pkg::IDX_PEND);
        `CHK("pending", 16'h1, rv[15:0]);
        wr(ddc_pkg::IDX_PEND, 16'h1);
        rd(ddc_pkg::IDX_PEND);
        `CHK("cancel", 16'h0, rv[15:0]);
        trig(1'b0);
        s = 28'h0100040;
        d = 28'h0100200;
        n0 = n_wr;
        setup(2'h2, 2'h0, 24'h000002);
        wait_wr(n0 + 16'h1);
        `CHK("queued", n0 + 16'h1, n_wr);
        chk_xfer();
        rd(ddc_pkg::IDX_PEND);
        `CHK("pending start", 16'h0, rv[15:0]);
        rd(ddc_pkg::IDX_SRC_LO);
        `CHK("src inc", 16'h0041, rv[15:0]);
        rd(ddc_pkg::IDX_DST_LO);
        `CHK("dst fixed", 16'h0200, rv[15:0]);
        wr(ddc_pkg::IDX_CNT_LO, 16'h1234);
        rd(ddc_pkg::IDX_CNT_LO);
        `CHK("count locked", 16'h0001, rv[15:0]);
        trig(1'b1);
        rd(ddc_pkg::IDX_ENABLE);
        `CHK("auto disable", 16'h0, rv[15:0]);
        rd(ddc_pkg::IDX_IRQ_STAT);
        `CHK("status", 16'h3, rv[15:0]);
        wr(ddc_pkg::IDX_IRQ_MASK, 16'h1);
        @(posedge clk);
        `CHK("irq done", 1'b1, irq);
        wr(ddc_pkg::IDX_IRQ_STAT, 16'h1);
        @(posedge clk);
        `CHK("irq clear", 1'b0, irq);
        wr(ddc_pkg::IDX_IRQ_MASK, 16'h2);
        @(posedge clk);
        `CHK("irq trig", 1'b1, irq);
        trig(1'b0);
        $display("test queue and irq done");
        for (int m = 0; m < 16; m++) begin
            s = 28'h0100000 | 28'($urandom_range(20'hFFFFF));
            d = 28'h0100000 | 28'($urandom_range(20'hFFFFF));
            wr(ddc_pkg::IDX_PEND, 16'h1);
            setup(2'(m >> 2), 2'(m), 24'h000001);
            trig(1'b1);
            chk_xfer();
            rd_a28(ddc_pkg::IDX_SRC_LO);
            `CHK("src next", stp(s, 2'(m >> 2)), a);
            rd_a28(ddc_pkg::IDX_DST_LO);
            `CHK("dst next", stp(d, 2'(m)), a);
        end
        $display("test step modes done");
        wr(ddc_pkg::IDX_PEND, 16'h1);
        setup(2'h3, 2'h1, 24'h010000);
        trig(1'b1);
        rd(ddc_pkg::IDX_CTRL);
        `CHK("count hi", 8'h00, rv[7:0]);
        rd(ddc_pkg::IDX_CNT_LO);
        `CHK("count lo", 16'hFFFF, rv[15:0]);
        wr(ddc_pkg::IDX_ENABLE, 16'h0);
        setup(2'h3, 2'h1, 24'h000000);
        trig(1'b1);
        trig(1'b1);
        rd(ddc_pkg::IDX_CTRL);
        `CHK("wrap hi", 8'hFF, rv[7:0]);
        rd(ddc_pkg::IDX_CNT_LO);
        `CHK("wrap lo", 16'hFFFE, rv[15:0]);
        rd(ddc_pkg::IDX_ENABLE);
        `CHK("still on", 16'h1, rv[15:0]);
        $display("test count wrap done");
        test_done();
    end
endmodule
`default_nettype wire
